// [hdl/blc_byte_lane_ctrl.sv]
// Purpose: Byte-lane masking of CPU word accesses and external memory port clock rate select
// Assumes: CPU issues one word access per cycle while o_cpu_busy is low
// Notes: All outputs come from the state register
//
// Contract
// - Memory-side lane select masks only external memory and its port registers.
// - USB lane select masks only USB register accesses, nothing else.
// - Port register access: 00b whole, 01b upper byte, 10b lower byte.
// - USB register access: 00b whole, 01b upper byte, 10b lower byte.
// - Word mode, 16-bit bus: one 16-bit external access per CPU word.
// - Word mode, 8-bit bus: two 8-bit external accesses per CPU word.
// - High-byte mode, 16-bit bus: one access, upper lane only.
// - Low-byte mode, 16-bit bus: one access, lower lane only.
// - Either byte mode, 8-bit bus: exactly one 8-bit access per word.
// - Lane field in bits 1-0 covers data and program; code 3h unused.
// - Rate bit 0 resets to 1: full rate when set, half when cleared.
// - Half rate applies to asynchronous and synchronous memory timing alike.
`include "blc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module blc_byte_lane_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire blc_pkg::blc_rbus_t i_rbus,
	output logic [15:0] o_rdata,
	input wire blc_pkg::blc_cpu_acc_t i_cpu,
	input wire logic [1:0] i_ext_bus_width_select,
	input wire logic [1:0] i_usb_byte_lane_select,
	output logic o_cpu_busy,
	output blc_pkg::blc_reg_acc_t o_reg_acc,
	output blc_pkg::blc_ext_acc_t o_ext,
	output logic o_full_rate_select,
	output logic o_async_tick,
	output logic o_sync_tick
);

	// ========================================
	// Lane decode, shared by both selects
	function automatic logic [1:0] lane_be(input logic [1:0] sel);
		logic [1:0] be;
		be = `BLC_BE_BOTH;
		if (sel == `BLC_LANE_HIGH) begin
			be = `BLC_BE_HIGH;
		end else if (sel == `BLC_LANE_LOW) begin
			be = `BLC_BE_LOW;
		end
		return be;
	endfunction

	blc_pkg::blc_state_t st_r;
	blc_pkg::blc_state_t st_nxt;
	logic bus8;

	// Anything but the 8-bit code is run as a 16-bit bus
	assign bus8 = (i_ext_bus_width_select == `BLC_BUS_8);

	// ========================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Read data stands one cycle only; unmapped reads give zero
		st_nxt.rdata = `BLC_RDATA_ZERO;
		st_nxt.reg_acc.valid = 1'b0;
		st_nxt.ext.req = 1'b0;

		// Register writes; reserved bits are simply not stored
		// reserved bits
		if (i_rbus.wr) begin
			if (i_rbus.addr == `BLC_ADDR_CLK_RATE) begin
				st_nxt.full_rate = i_rbus.wdata[`BLC_FULL_RATE_BIT];
			end else if (i_rbus.addr == `BLC_ADDR_BYTE_LANE) begin
				if (i_rbus.wdata[`BLC_LANE_MSB:`BLC_LANE_LSB] != `BLC_LANE_RSVD) begin
					st_nxt.lane = i_rbus.wdata[`BLC_LANE_MSB:`BLC_LANE_LSB];
				end
			end
		end

		// Register reads, zero above the fields
		// reads zero
		if (i_rbus.rd) begin
			if (i_rbus.addr == `BLC_ADDR_CLK_RATE) begin
				st_nxt.rdata = {15'h0000, st_r.full_rate};
			end else if (i_rbus.addr == `BLC_ADDR_BYTE_LANE) begin
				st_nxt.rdata = {14'h0000, st_r.lane};
			end
		end

		// One divider feeds both timing engines so they never drift apart
		// rate select
		st_nxt.div_ph = st_r.full_rate ? 1'b0 : ~st_r.div_ph;
		st_nxt.async_tick = st_r.full_rate | ~st_r.div_ph;
		st_nxt.sync_tick = st_r.full_rate | ~st_r.div_ph;

		// CPU access translation
		case (st_r.seq)
			blc_pkg::BLC_IDLE: begin
				if (i_cpu.valid) begin
					if (i_cpu.space == blc_pkg::BLC_SP_EXT_MEM) begin
						st_nxt.ext.req = 1'b1;
						st_nxt.ext.write = i_cpu.write;
						st_nxt.ext.be = lane_be(st_r.lane);
						if (bus8) begin
							st_nxt.ext.w16 = 1'b0;
							if (st_r.lane == `BLC_LANE_WORD) begin
								st_nxt.ext.be = `BLC_BE_LOW;
								st_nxt.seq = blc_pkg::BLC_SECOND;
								st_nxt.busy = 1'b1;
							end
						end else begin
							st_nxt.ext.w16 = 1'b1;
						end
					end else begin
						st_nxt.reg_acc.valid = 1'b1;
						st_nxt.reg_acc.write = i_cpu.write;
						st_nxt.reg_acc.space = i_cpu.space;
						st_nxt.reg_acc.be = `BLC_BE_BOTH;
						if (i_cpu.space == blc_pkg::BLC_SP_EXTERNAL_MEMORY_PORT_REG) begin
							st_nxt.reg_acc.be = lane_be(st_r.lane);
						end else if (i_cpu.space == blc_pkg::BLC_SP_USB_REG) begin
							st_nxt.reg_acc.be = lane_be(i_usb_byte_lane_select);
						end
					end
				end
			end
			blc_pkg::BLC_SECOND: begin
				// Upper byte of a split word; requests meanwhile are dropped
				st_nxt.ext.req = 1'b1;
				st_nxt.ext.w16 = 1'b0;
				st_nxt.ext.be = `BLC_BE_HIGH;
				st_nxt.seq = blc_pkg::BLC_IDLE;
				st_nxt.busy = 1'b0;
			end
			default: begin
				st_nxt.seq = blc_pkg::BLC_IDLE;
			end
		endcase
	end

	// ========================================
	// State register, synchronous reset
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			st_r <= '0;
			st_r.lane <= `BLC_BYTE_LANE_RST;
			st_r.full_rate <= `BLC_CLK_RATE_RST;
			st_r.seq <= blc_pkg::BLC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ========================================
	// Outputs
	assign o_rdata = st_r.rdata;
	assign o_cpu_busy = st_r.busy;
	assign o_reg_acc = st_r.reg_acc;
	assign o_ext = st_r.ext;
	assign o_full_rate_select = st_r.full_rate;
	assign o_async_tick = st_r.async_tick;
	assign o_sync_tick = st_r.sync_tick;

	// ========================================
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	logic idle_acc;
	assign idle_acc = i_cpu.valid && !st_r.busy;

	AST_MEM_NOT_ON_REGS: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXT_MEM |=> !o_reg_acc.valid && o_ext.req)
		else $error("memory access leaked onto register path");
	AST_OTHER_WHOLE: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_OTHER |=> o_reg_acc.valid && o_reg_acc.be == `BLC_BE_BOTH)
		else $error("other access was masked");
	AST_PORT_REG_LANE: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXTERNAL_MEMORY_PORT_REG
		|=> o_reg_acc.valid && o_reg_acc.be == lane_be($past(st_r.lane)))
		else $error("port register byte enable wrong");
	AST_USB_LANE: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_USB_REG
		|=> o_reg_acc.valid && o_reg_acc.be == lane_be($past(i_usb_byte_lane_select)))
		else $error("USB register byte enable wrong");
	AST_WORD16_ONE: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXT_MEM && !bus8 && st_r.lane == `BLC_LANE_WORD
		|=> o_ext.req && o_ext.w16 && o_ext.be == `BLC_BE_BOTH && !o_cpu_busy)
		else $error("word on 16-bit bus not single access");
	AST_WORD8_SPLIT: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXT_MEM && bus8 && st_r.lane == `BLC_LANE_WORD
		|=> o_ext.req && !o_ext.w16 && o_ext.be == `BLC_BE_LOW && o_cpu_busy
		##1 o_ext.req && !o_ext.w16 && o_ext.be == `BLC_BE_HIGH && !o_cpu_busy)
		else $error("word on 8-bit bus not split in two");
	AST_HIGH16: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXT_MEM && !bus8 && st_r.lane == `BLC_LANE_HIGH
		|=> o_ext.req && o_ext.w16 && o_ext.be == `BLC_BE_HIGH)
		else $error("high-byte mode lane wrong");
	AST_LOW16: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXT_MEM && !bus8 && st_r.lane == `BLC_LANE_LOW
		|=> o_ext.req && o_ext.w16 && o_ext.be == `BLC_BE_LOW)
		else $error("low-byte mode lane wrong");
	AST_BYTE8_ONE: assert property (
		idle_acc && i_cpu.space == blc_pkg::BLC_SP_EXT_MEM && bus8 && st_r.lane != `BLC_LANE_WORD
		|=> o_ext.req && !o_ext.w16 && o_ext.be == lane_be($past(st_r.lane)) && !o_cpu_busy)
		else $error("byte mode on 8-bit bus not one access");
	AST_RSVD_CODE: assert property (
		i_rbus.wr && i_rbus.addr == `BLC_ADDR_BYTE_LANE && i_rbus.wdata[1:0] == `BLC_LANE_RSVD
		|=> $stable(st_r.lane) && st_r.lane != `BLC_LANE_RSVD)
		else $error("reserved lane code accepted");
	AST_FULL_RATE: assert property (
		o_full_rate_select && $past(o_full_rate_select) && $past(i_nrst) |-> o_async_tick)
		else $error("full rate missed a tick");
	AST_HALF_RATE: assert property (
		!o_full_rate_select [*3] |-> o_async_tick != $past(o_async_tick))
		else $error("half rate not alternating");
	AST_SHARED_TIMING: assert property (
		!o_full_rate_select |-> o_sync_tick == o_async_tick)
		else $error("timing engines diverge");
	AST_RSVD_READ: assert property (
		i_rbus.rd && i_rbus.addr == `BLC_ADDR_CLK_RATE |=> o_rdata[15:1] == 15'h0000)
		else $error("reserved bits read nonzero");

	COV_SPLIT: cover property (o_ext.req && o_ext.be == `BLC_BE_LOW ##1 o_ext.req && o_ext.be == `BLC_BE_HIGH);
	COV_USB_HIGH: cover property (o_reg_acc.valid && o_reg_acc.space == blc_pkg::BLC_SP_USB_REG
		&& o_reg_acc.be == `BLC_BE_HIGH);
	COV_HALF_RATE: cover property (!o_full_rate_select [*4]);
	COV_HIGH16: cover property (o_ext.req && o_ext.w16 && o_ext.be == `BLC_BE_HIGH);
	COV_RSVD_WRITE: cover property (i_rbus.wr && i_rbus.addr == `BLC_ADDR_BYTE_LANE
		&& i_rbus.wdata[1:0] == `BLC_LANE_RSVD);

	// ========================================
	// Register port checks
	// Read data must drop after one cycle, or a late sampler sees stale data
	AST_RDATA_ONE_CYCLE: assert property (
		!i_rbus.rd |=> o_rdata == `BLC_RDATA_ZERO)
		else $error("read data stood too long");
	// A legal lane code lands on the next edge
	AST_LANE_WRITE: assert property (
		i_rbus.wr && i_rbus.addr == `BLC_ADDR_BYTE_LANE && i_rbus.wdata[1:0] != `BLC_LANE_RSVD
		|=> st_r.lane == $past(i_rbus.wdata[1:0]))
		else $error("lane write lost");
	// The unused code can never be held, whatever software writes
	AST_LANE_NEVER_RSVD: assert property (
		st_r.lane != `BLC_LANE_RSVD)
		else $error("lane holds unused code");
	// Only bit 0 of the rate register is stored
	AST_RATE_WRITE: assert property (
		i_rbus.wr && i_rbus.addr == `BLC_ADDR_CLK_RATE
		|=> o_full_rate_select == $past(i_rbus.wdata[0]))
		else $error("rate write lost");
	AST_READ_RATE: assert property (
		i_rbus.rd && i_rbus.addr == `BLC_ADDR_CLK_RATE |=> o_rdata[0] == $past(o_full_rate_select))
		else $error("rate read back wrong");
	AST_READ_LANE: assert property (
		i_rbus.rd && i_rbus.addr == `BLC_ADDR_BYTE_LANE |=> o_rdata == {14'h0000, $past(st_r.lane)})
		else $error("lane read back wrong");

	// ========================================
	// CPU handshake checks
	// A request meeting the busy cycle is dropped, never half issued
	AST_BUSY_DROP: assert property (
		i_cpu.valid && st_r.busy |=> !o_reg_acc.valid)
		else $error("request taken while busy");
	// Busy covers exactly the first, low-byte half of a split word
	AST_BUSY_ONE: assert property (
		o_cpu_busy |=> !o_cpu_busy)
		else $error("busy held too long");
	// Register-space accesses never reach the external bus
	AST_OTHER_NO_EXT: assert property (
		idle_acc && i_cpu.space != blc_pkg::BLC_SP_EXT_MEM |=> !o_ext.req)
		else $error("register access reached external bus");
	// Both timing engines follow the rate in full-rate mode too
	AST_FULL_SHARED: assert property (
		o_full_rate_select |-> o_sync_tick == o_async_tick)
		else $error("timing engines diverge at full rate");

endmodule

`default_nettype wire

// [hdl/blc_consts.svh]
// Purpose: Offsets, field positions, reset values and codes of the byte-lane and clock control block
// Assumes: 16-bit register port, registers at their printed word offsets
// Notes: Definitions only
`ifndef BLC_CONSTS_SVH
`define BLC_CONSTS_SVH

// ========================================
// Register offsets
`define BLC_ADDR_CLK_RATE 16'h1c26
`define BLC_ADDR_BYTE_LANE 16'h1c33

// ========================================
// Fields and reset values
`define BLC_FULL_RATE_BIT 0
`define BLC_LANE_MSB 1
`define BLC_LANE_LSB 0
`define BLC_CLK_RATE_RST 1'h1
`define BLC_BYTE_LANE_RST 2'h0
`define BLC_RDATA_ZERO 16'h0000

// ========================================
// Byte-lane select codes
`define BLC_LANE_WORD 2'h0
`define BLC_LANE_HIGH 2'h1
`define BLC_LANE_LOW 2'h2
`define BLC_LANE_RSVD 2'h3

// ========================================
// External bus width codes
`define BLC_BUS_8 2'h0
`define BLC_BUS_16 2'h1

// ========================================
// Byte enables, bit 1 is the upper byte
`define BLC_BE_BOTH 2'h3
`define BLC_BE_HIGH 2'h2
`define BLC_BE_LOW 2'h1

`endif

// [hdl/blc_pkg.sv]
// Purpose: Types of the byte-lane and clock control block
// Assumes: Constants live in blc_consts.svh
// Notes: Nothing here is imported, users write blc_pkg::name
package blc_pkg;

	// ========================================
	// Address spaces a CPU word access can target
	typedef enum logic [1:0] {
		BLC_SP_OTHER,
		BLC_SP_EXT_MEM,
		BLC_SP_EXTERNAL_MEMORY_PORT_REG,
		BLC_SP_USB_REG
	} blc_space_t;

	// Split sequencer for an 8-bit external bus
	typedef enum logic {
		BLC_IDLE,
		BLC_SECOND
	} blc_seq_t;

	// Register port from software
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} blc_rbus_t;

	// CPU word access request
	typedef struct packed {
		logic valid;
		logic write;
		blc_space_t space;
	} blc_cpu_acc_t;

	// Register-space access with byte enables
	typedef struct packed {
		logic valid;
		logic write;
		blc_space_t space;
		logic [1:0] be;
	} blc_reg_acc_t;

	// External memory access; on an 8-bit bus be names the CPU byte carried
	typedef struct packed {
		logic req;
		logic write;
		logic w16;
		logic [1:0] be;
	} blc_ext_acc_t;

	// Whole state of the block
	typedef struct packed {
		logic [1:0] lane;
		logic full_rate;
		logic [15:0] rdata;
		logic div_ph;
		logic async_tick;
		logic sync_tick;
		blc_seq_t seq;
		logic busy;
		blc_reg_acc_t reg_acc;
		blc_ext_acc_t ext;
	} blc_state_t;

endpackage

// [verification/blc_cpu_model.sv]
// Purpose: CPU core that issues one word access for each go pulse from the bench seen while i_cpu_busy is low
// Assumes: Requests launch right after a rising edge and last one cycle
// Notes: Idle qualifiers flip so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none

module blc_cpu_model (
	input wire logic i_ref_clk,
	input wire logic i_go,
	input wire logic i_write,
	input wire blc_pkg::blc_space_t i_space,
	input wire logic i_cpu_busy,
	output blc_pkg::blc_cpu_acc_t o_cpu
);
	// ========================================
	// Request launch
	// A go pulse seen while busy is dropped, not held, so that request is lost
	always_ff @(posedge i_ref_clk) begin
		o_cpu.valid <= i_go & ~i_cpu_busy;
		o_cpu.write <= i_go ? i_write : ~o_cpu.write;
		o_cpu.space <= i_go ? i_space : blc_pkg::blc_space_t'(~o_cpu.space);
	end
endmodule

`default_nettype wire

// [verification/byte_lane_and_clock_ctrl_test.sv]
// Purpose: Self-checking bench of the byte-lane and clock control block
// Assumes: Register port strobes one cycle, read data the cycle after
// Notes: Table rows cover lane, bus width and space; register cases follow
`include "blc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module byte_lane_and_clock_ctrl_test;
	typedef struct packed {
		logic [1:0] lane;
		logic [1:0] wid;
		logic [1:0] usb;
		blc_pkg::blc_space_t sp;
		logic [1:0] be;
		logic split;
	} blc_row_t;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic go = 1'b0;
	logic wrt = 1'b0;
	logic tick_a;
	blc_pkg::blc_space_t space = blc_pkg::BLC_SP_OTHER;
	blc_pkg::blc_rbus_t rbus = '0;
	blc_pkg::blc_cpu_acc_t cpu;
	logic [1:0] wid = 2'h1;
	logic [1:0] usb = 2'h0;
	logic [15:0] rdata;
	logic busy;
	logic full_rate;
	logic async_tick;
	logic sync_tick;
	blc_pkg::blc_reg_acc_t reg_acc;
	blc_pkg::blc_ext_acc_t ext;
	int mismatches = 0;
	int num_checks = 0;
	// lane modes aimed at external memory, port and USB registers
	blc_row_t rows [13] = '{
		'{2'h0, 2'h1, 2'h0, blc_pkg::BLC_SP_EXT_MEM, 2'h3, 1'b0}, '{2'h1, 2'h1, 2'h0, blc_pkg::BLC_SP_EXT_MEM, 2'h2, 1'b0},
		'{2'h2, 2'h1, 2'h0, blc_pkg::BLC_SP_EXT_MEM, 2'h1, 1'b0}, '{2'h0, 2'h0, 2'h0, blc_pkg::BLC_SP_EXT_MEM, 2'h1, 1'b1},
		'{2'h1, 2'h0, 2'h0, blc_pkg::BLC_SP_EXT_MEM, 2'h2, 1'b0}, '{2'h2, 2'h0, 2'h0, blc_pkg::BLC_SP_EXT_MEM, 2'h1, 1'b0},
		'{2'h0, 2'h0, 2'h1, blc_pkg::BLC_SP_EXTERNAL_MEMORY_PORT_REG, 2'h3, 1'b0}, '{2'h1, 2'h0, 2'h0, blc_pkg::BLC_SP_EXTERNAL_MEMORY_PORT_REG, 2'h2, 1'b0},
		'{2'h2, 2'h1, 2'h2, blc_pkg::BLC_SP_EXTERNAL_MEMORY_PORT_REG, 2'h1, 1'b0}, '{2'h1, 2'h0, 2'h0, blc_pkg::BLC_SP_USB_REG, 2'h3, 1'b0},
		'{2'h0, 2'h0, 2'h1, blc_pkg::BLC_SP_USB_REG, 2'h2, 1'b0}, '{2'h2, 2'h0, 2'h2, blc_pkg::BLC_SP_USB_REG, 2'h1, 1'b0},
		'{2'h1, 2'h1, 2'h3, blc_pkg::BLC_SP_USB_REG, 2'h3, 1'b0}};

	// ========================================
	// Clock and instances
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	blc_cpu_model cpu_model (.i_ref_clk(ref_clk), .i_go(go), .i_write(wrt), .i_space(space), .i_cpu_busy(busy),
		.o_cpu(cpu));
	blc_byte_lane_ctrl dut (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_rbus(rbus), .o_rdata(rdata), .i_cpu(cpu),
		.i_ext_bus_width_select(wid), .i_usb_byte_lane_select(usb), .o_cpu_busy(busy), .o_reg_acc(reg_acc),
		.o_ext(ext), .o_full_rate_select(full_rate), .o_async_tick(async_tick), .o_sync_tick(sync_tick));

	// ========================================
	// Compare and bus tasks
	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [15:0] addr, input logic [15:0] data);
		@(posedge ref_clk);
		rbus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		rbus.wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
		@(posedge ref_clk);
		rbus <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		rbus.rd <= 1'b0;
		#1 chk16("rdata", exp, rdata);
	endtask
	// Go pulse, model launches next edge, design takes the edge after
	task automatic acc(input blc_pkg::blc_space_t sp, input logic wr);
		@(posedge ref_clk);
		go <= 1'b1;
		space <= sp;
		wrt <= wr;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ========================================
	// Watchdog, far beyond the hundred or so cycles needed
	initial begin
		#(8 * 5000);
		mismatches++;
		end_of_test();
	end

	// ========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		chk8("rate_rst", 8'h01, {7'h0, full_rate});
		nrst <= 1'b1;
		rd_chk(`BLC_ADDR_CLK_RATE, 16'h0001);
		rd_chk(`BLC_ADDR_BYTE_LANE, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 13; i++) begin
			wr_reg(`BLC_ADDR_BYTE_LANE, {14'h0, rows[i].lane});
			wid <= rows[i].wid;
			usb <= rows[i].usb;
			acc(rows[i].sp, i[0]);
			if (rows[i].sp == blc_pkg::BLC_SP_EXT_MEM) begin
				chk8("ext", {3'h0, 1'b1, i[0], rows[i].wid != 2'h0, rows[i].be}, {3'h0, ext});
				chk8("reg_idle", 8'h00, {7'h0, reg_acc.valid});
				if (rows[i].split) begin
					chk8("busy", 8'h01, {7'h0, busy});
					@(posedge ref_clk);
					#1 chk8("ext_hi", {3'h0, 1'b1, i[0], 1'b0, 2'h2}, {3'h0, ext});
					chk8("busy_end", 8'h00, {7'h0, busy});
				end
			end else begin
				chk8("reg", {2'h0, 1'b1, i[0], rows[i].sp, rows[i].be}, {2'h0, reg_acc});
				chk8("ext_idle", 8'h00, {7'h0, ext.req});
			end
		end
		$display("test rows done");
		wr_reg(`BLC_ADDR_BYTE_LANE, 16'hfff2);
		rd_chk(`BLC_ADDR_BYTE_LANE, 16'h0002);
		wr_reg(`BLC_ADDR_BYTE_LANE, 16'h0003);
		rd_chk(`BLC_ADDR_BYTE_LANE, 16'h0002);
		rd_chk(16'h1c34, 16'h0000);
		$display("test lane register done");
		wr_reg(`BLC_ADDR_CLK_RATE, 16'hfffe);
		#1 chk8("half", 8'h00, {7'h0, full_rate});
		rd_chk(`BLC_ADDR_CLK_RATE, 16'h0000);
		@(posedge ref_clk);
		#1 tick_a = async_tick;
		@(posedge ref_clk);
		#1 chk8("tick_alt", {7'h0, ~tick_a}, {7'h0, async_tick});
		chk8("sync_tick", {7'h0, async_tick}, {7'h0, sync_tick});
		wr_reg(`BLC_ADDR_CLK_RATE, 16'h0001);
		repeat (2) @(posedge ref_clk);
		#1 chk8("full_ticks", 8'h03, {6'h0, async_tick, sync_tick});
		$display("test clock rate done");
		end_of_test();
	end
endmodule

`default_nettype wire
